// ==== core/video_output_control.sv ====
// register file and pixel output port control
`timescale 1ns/1ns
`default_nettype none
module video_output_control
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] luma_in,
   input wire logic [7:0] chroma_in,
   input wire logic pixel_valid,
   input wire logic [9:0] line_number,
   input wire logic vertical_blank,
   input wire logic field_end,
   input wire logic horizontal_lock,
   input wire logic [6:0] fifo_level,
   input wire logic tick_27mhz,
   input wire logic external_input_clock,
   input wire logic output_enable_n,
   output logic [15:0] pixel_out,
   output logic pixel_oe,
   output logic half_rate_pixel_clock,
   output logic [11:0] extra_data_out,
   output logic extra_data_oe,
   output logic [3:0] general_outputs,
   output logic [3:0] general_outputs_oe,
   output logic minimal_filter,
   output logic full_range,
   output logic stream_rev_new,
   output logic fifo_reset,
   output logic almost_empty_flag,
   output logic almost_full_flag,
   output logic half_full_flag,
   output logic irq
);
   import video_out_pkg::*;
   function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] hi);
      clamp = (v < LUMA_MIN) ? LUMA_MIN : ((v > hi) ? hi : v);
   endfunction
   function automatic logic fmt_known(input logic [3:0] f);
      fmt_known = (f == FMT_16BIT_422) || (f == FMT_8BIT_422) || (f == FMT_12BIT_411);
   endfunction

   bus_state_t state_reg;
   logic [7:0] addr_reg, rd_next, output_control_reg, fifo_control_reg;
   logic [7:0] extended_output_control_reg, general_purpose_output_reg;
   logic [3:0] irq_status_reg, irq_mask_reg, irq_event;
   logic oe_meta_reg, oe_sync_reg;
   logic clk_meta_reg, clk_sync_reg, clk_prev_reg;
   logic lock_prev_reg;
   logic [7:0] luma_q_reg, chroma_q_reg;
   logic valid_q_reg, phase_reg;
   logic [1:0] mode;
   logic [3:0] fmt;
   logic [4:0] margin;
   logic cfg_ok, flag_tick, gp_format, wr_ok;

   assign mode = output_control_reg[MODE_LSB +: 2];
   assign fmt = output_control_reg[FORMAT_LSB +: 4];
   assign margin = fifo_control_reg[MARGIN_LSB +: 5];
   // invalid mode or unused format keeps the pixel bus quiet
   assign cfg_ok = (mode != MODE_INVALID) && fmt_known(fmt);
   assign gp_format = (fmt == FMT_8BIT_422) || (fmt == FMT_12BIT_411);
   assign wr_ok = (state_reg == BUS_WRITE);

   // bus: zero-wait writes, reads take one wait state so a just-written value is seen
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= BUS_IDLE;
         addr_reg <= 8'h00;
      end
      else if (state_reg == BUS_READ_WAIT)
         state_reg <= BUS_READ_DONE;
      else if (hsel && hready && htrans[1])
      begin
         state_reg <= hwrite ? BUS_WRITE : BUS_READ_WAIT;
         addr_reg <= haddr[9:2];
      end
      else if (hready)
         state_reg <= BUS_IDLE;
   end

   assign hreadyout = (state_reg != BUS_READ_WAIT);
   assign hresp = 1'b0;
   always_comb
   begin
      case (addr_reg)
         IDX_OUTPUT_CONTROL: rd_next = output_control_reg;
         IDX_EXTENDED_OUTPUT_CONTROL: rd_next = extended_output_control_reg;
         IDX_GENERAL_PURPOSE_OUTPUT: rd_next = general_purpose_output_reg;
         IDX_FIFO_CONTROL: rd_next = fifo_control_reg;
         IDX_IRQ_STATUS: rd_next = {4'h0, irq_status_reg};
         IDX_IRQ_MASK: rd_next = {4'h0, irq_mask_reg};
         IDX_BLOCK_STATE: rd_next = {2'h0, horizontal_lock, cfg_ok, half_full_flag,
                                     almost_full_flag, almost_empty_flag, fifo_reset};
         default: rd_next = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (state_reg == BUS_READ_WAIT)
         hrdata <= {24'h000000, rd_next};
   end

   // control registers; reserved extended bits are stored as written
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         output_control_reg <= RST_OUTPUT_CONTROL;
         extended_output_control_reg <= RST_EXTENDED_OUTPUT_CONTROL;
         general_purpose_output_reg <= RST_GENERAL_PURPOSE_OUTPUT;
         irq_mask_reg <= 4'h0;
      end
      else if (wr_ok)
      begin
         if (addr_reg == IDX_OUTPUT_CONTROL)
            output_control_reg <= hwdata[7:0];
         if (addr_reg == IDX_EXTENDED_OUTPUT_CONTROL)
            extended_output_control_reg <= hwdata[7:0];
         if (addr_reg == IDX_GENERAL_PURPOSE_OUTPUT)
            general_purpose_output_reg <= hwdata[7:0];
         if (addr_reg == IDX_IRQ_MASK)
            irq_mask_reg <= hwdata[3:0];
      end
   end

   // fifo control: reset bit stays one for a cycle, then clears itself
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fifo_control_reg <= RST_FIFO_CONTROL;
      else if (wr_ok && addr_reg == IDX_FIFO_CONTROL)
         fifo_control_reg <= hwdata[7:0];
      else
         fifo_control_reg[FIFO_RESET_BIT] <= 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fifo_reset <= 1'b0;
      else
         fifo_reset <= fifo_control_reg[FIFO_RESET_BIT] ||
                       (field_end && fifo_control_reg[AUTO_RESET_BIT]);
   end

   // interrupts: sticky, write one to clear, a new event wins over the clear
   assign irq_event[IRQ_FIFO_RESET] = fifo_reset;
   assign irq_event[IRQ_FIELD_END] = field_end;
   assign irq_event[IRQ_BAD_CONFIG] = !cfg_ok;
   assign irq_event[IRQ_LOCK_CHANGE] = horizontal_lock ^ lock_prev_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_status_reg <= 4'h0;
         lock_prev_reg <= 1'b0;
      end
      else
      begin
         lock_prev_reg <= horizontal_lock;
         if (wr_ok && addr_reg == IDX_IRQ_STATUS)
            irq_status_reg <= (irq_status_reg & ~hwdata[3:0]) | irq_event;
         else
            irq_status_reg <= irq_status_reg | irq_event;
      end
   end
   assign irq = |(irq_status_reg & irq_mask_reg);
   // pin synchronisers; the enable pin and the external clock come from outside
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         oe_meta_reg <= 1'b1;
         oe_sync_reg <= 1'b1;
         clk_meta_reg <= 1'b0;
         clk_sync_reg <= 1'b0;
         clk_prev_reg <= 1'b0;
      end
      else
      begin
         oe_meta_reg <= output_enable_n;
         oe_sync_reg <= oe_meta_reg;
         clk_meta_reg <= external_input_clock;
         clk_sync_reg <= clk_meta_reg;
         clk_prev_reg <= clk_sync_reg;
      end
   end

   // flags refresh on the chosen timebase or on a fifo reset
   assign flag_tick = fifo_control_reg[FLAG_TIMING_BIT] ? tick_27mhz :
                      (clk_sync_reg && !clk_prev_reg);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         almost_empty_flag <= 1'b1;
         almost_full_flag <= 1'b0;
         half_full_flag <= 1'b0;
      end
      else if (fifo_reset || flag_tick)
      begin
         almost_empty_flag <= fifo_reset || (fifo_level <= {2'b00, margin});
         almost_full_flag <= !fifo_reset && (fifo_level >= (FIFO_DEPTH - {2'b00, margin}));
         half_full_flag <= !fifo_reset && (fifo_level >= FIFO_HALF);
      end
   end

   // stage one: range limit and chroma blanking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         luma_q_reg <= LUMA_MIN;
         chroma_q_reg <= CHROMA_ZERO;
         valid_q_reg <= 1'b0;
         minimal_filter <= 1'b0;
      end
      else
      begin
         valid_q_reg <= pixel_valid;
         minimal_filter <= output_control_reg[BLANK_PASS_BIT] && vertical_blank &&
                           line_number != 10'h000 && line_number <= BLANK_LAST_LINE;
         if (pixel_valid)
         begin
            luma_q_reg <= extended_output_control_reg[RANGE_BIT] ? luma_in :
                          clamp(luma_in, LUMA_MAX);
            if (vertical_blank && general_purpose_output_reg[CHROMA_BLANK_BIT])
               chroma_q_reg <= CHROMA_ZERO;
            else
               chroma_q_reg <= extended_output_control_reg[RANGE_BIT] ? chroma_in :
                               clamp(chroma_in, CHROMA_MAX);
         end
      end
   end

   // stage two: bus packing; 8-bit format alternates chroma then luma
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pixel_out <= 16'h0000;
         phase_reg <= 1'b0;
         half_rate_pixel_clock <= 1'b0;
         extra_data_out <= 12'h000;
      end
      else if (valid_q_reg)
      begin
         phase_reg <= !phase_reg;
         half_rate_pixel_clock <= !half_rate_pixel_clock;
         extra_data_out <= {chroma_q_reg, luma_q_reg[3:0]};
         case (fmt)
            FMT_16BIT_422: pixel_out <= {luma_q_reg, chroma_q_reg};
            FMT_8BIT_422: pixel_out <= {8'h00, phase_reg ? luma_q_reg : chroma_q_reg};
            FMT_12BIT_411: pixel_out <= {4'h0, luma_q_reg, chroma_q_reg[7:4]};
            default: pixel_out <= 16'h0000;
         endcase
      end
   end

   // driver enables and general outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pixel_oe <= 1'b0;
         extra_data_oe <= 1'b0;
         general_outputs <= 4'h0;
         general_outputs_oe <= 4'h0;
         full_range <= 1'b0;
         stream_rev_new <= 1'b0;
      end
      else
      begin
         pixel_oe <= cfg_ok && !output_control_reg[THREE_STATE_BIT] && !oe_sync_reg;
         extra_data_oe <= cfg_ok && !output_control_reg[THREE_STATE_BIT] && !oe_sync_reg &&
                          extended_output_control_reg[EXTRA_LSB +: 3] != 3'h0;
         full_range <= extended_output_control_reg[RANGE_BIT];
         stream_rev_new <= extended_output_control_reg[STREAM_REV_BIT];
         general_outputs[3:1] <= general_purpose_output_reg[3:1];
         if (general_purpose_output_reg[LOCK_IND_BIT] && mode != MODE_LINE_LOCKED)
            general_outputs[0] <= horizontal_lock;
         else
            general_outputs[0] <= general_purpose_output_reg[0];
         general_outputs_oe[1:0] <= {2{gp_format && general_purpose_output_reg[LOW_PAIR_BIT]}};
         general_outputs_oe[3:2] <= {2{gp_format && general_purpose_output_reg[HIGH_PAIR_BIT]}};
      end
   end

   property p_three_state;
      @(posedge hclk) disable iff (!hresetn)
      output_control_reg[THREE_STATE_BIT] |=> !pixel_oe;
   endproperty
   a_three_state: assert property (p_three_state) else $error("pixel drivers on while forced off");

   property p_pin_follow;
      @(posedge hclk) disable iff (!hresetn)
      $fell(oe_sync_reg) && cfg_ok && !output_control_reg[THREE_STATE_BIT]
      && $stable(output_control_reg) |=> pixel_oe;
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pixel drivers ignore enable pin");

   property p_bad_mode;
      @(posedge hclk) disable iff (!hresetn)
      mode == MODE_INVALID |=> !pixel_oe && irq_status_reg[IRQ_BAD_CONFIG];
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("invalid mode drives bus");

   property p_range;
      @(posedge hclk) disable iff (!hresetn)
      pixel_valid && !extended_output_control_reg[RANGE_BIT]
      |=> luma_q_reg >= LUMA_MIN && luma_q_reg <= LUMA_MAX;
   endproperty
   a_range: assert property (p_range) else $error("luma outside broadcast range");

   property p_chroma_blank;
      @(posedge hclk) disable iff (!hresetn)
      pixel_valid && vertical_blank && general_purpose_output_reg[CHROMA_BLANK_BIT]
      |=> chroma_q_reg == CHROMA_ZERO;
   endproperty
   a_chroma_blank: assert property (p_chroma_blank) else $error("chroma not blanked");

   property p_extra_off;
      @(posedge hclk) disable iff (!hresetn)
      extended_output_control_reg[EXTRA_LSB +: 3] == 3'h0 |=> !extra_data_oe;
   endproperty
   a_extra_off: assert property (p_extra_off) else $error("extra pins driven with select 000");

   property p_low_pair;
      @(posedge hclk) disable iff (!hresetn)
      !general_purpose_output_reg[LOW_PAIR_BIT] |=> general_outputs_oe[1:0] == 2'b00;
   endproperty
   a_low_pair: assert property (p_low_pair) else $error("low pair driven while disabled");

   property p_high_pair;
      @(posedge hclk) disable iff (!hresetn)
      !general_purpose_output_reg[HIGH_PAIR_BIT] |=> general_outputs_oe[3:2] == 2'b00;
   endproperty
   a_high_pair: assert property (p_high_pair) else $error("high pair driven while disabled");

   property p_lock_pin;
      @(posedge hclk) disable iff (!hresetn)
      general_purpose_output_reg[LOCK_IND_BIT] && mode != MODE_LINE_LOCKED
      |=> general_outputs[0] == $past(horizontal_lock);
   endproperty
   a_lock_pin: assert property (p_lock_pin) else $error("pin 0 not showing lock");

   property p_soft_reset;
      @(posedge hclk) disable iff (!hresetn)
      fifo_control_reg[FIFO_RESET_BIT] |=> fifo_reset ##1 !fifo_control_reg[FIFO_RESET_BIT] || wr_ok;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("fifo reset bit misbehaves");

   property p_auto_reset;
      @(posedge hclk) disable iff (!hresetn)
      field_end && fifo_control_reg[AUTO_RESET_BIT] |=> fifo_reset;
   endproperty
   a_auto_reset: assert property (p_auto_reset) else $error("no fifo reset at field end");

   property p_blank_pass;
      @(posedge hclk) disable iff (!hresetn)
      !output_control_reg[BLANK_PASS_BIT] |=> !minimal_filter;
   endproperty
   a_blank_pass: assert property (p_blank_pass) else $error("filter bypass while disabled");

   property p_flag_hold;
      @(posedge hclk) disable iff (!hresetn)
      !flag_tick && !fifo_reset |=> $stable(almost_full_flag) && $stable(almost_empty_flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag moved off its timebase");

   property p_full_flag;
      @(posedge hclk) disable iff (!hresetn)
      flag_tick && !fifo_reset && fifo_level == FIFO_DEPTH |=> almost_full_flag && !almost_empty_flag;
   endproperty
   a_full_flag: assert property (p_full_flag) else $error("almost full missing at full");
endmodule
`default_nettype wire

// ==== common/video_out_pkg.sv ====
// constants and types for the video output control block
// How it works
// - two-bit timing mode picks line-locked, simplified pixel, or pixel interface; 11 invalid.
// - four-bit format picks 16-bit 4:2:2, 8-bit 4:2:2 or 12-bit 4:1:1.
// - three-state bit set forces pixel drivers off; clear lets the enable pin decide.
// - blanking-pass bit lets vertical blanking lines 1 to 21 skip full filtering.
// - range bit clear clamps codes to broadcast range; set allows full range.
// - extra-data select 000 outputs nothing and three-states the 12 extra pins.
// - stream revision bit picks older or newer embedded-sync compatibility.
// - four general output bits drive the general pins in selected formats.
// - low-pair enable drives general outputs 0 and 1, else three-stated.
// - high-pair enable drives general outputs 2 and 3, else three-stated.
// - chroma-blank bit blanks both colour-difference samples during vertical blanking.
// - lock-indicator enable puts horizontal lock on general pin 0 in any mode except line-locked.
// - five-bit margin places almost-empty and almost-full flag thresholds; default 00100.
// - writing one to fifo reset resets the fifo and the bit self-clears.
// - auto-reset bit resets the fifo at the end of every field.
// - flag timing bit times fifo flags from external clock or 27 MHz tick.
package video_out_pkg;
   localparam logic [7:0] IDX_OUTPUT_CONTROL = 8'h03;
   localparam logic [7:0] IDX_EXTENDED_OUTPUT_CONTROL = 8'h04;
   localparam logic [7:0] IDX_GENERAL_PURPOSE_OUTPUT = 8'h05;
   localparam logic [7:0] IDX_FIFO_CONTROL = 8'h07;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
   localparam logic [7:0] IDX_BLOCK_STATE = 8'h12;
   localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h0C;
   localparam logic [7:0] RST_EXTENDED_OUTPUT_CONTROL = 8'h0C;
   localparam logic [7:0] RST_GENERAL_PURPOSE_OUTPUT = 8'h00;
   localparam logic [7:0] RST_FIFO_CONTROL = 8'h04;
   localparam int MODE_LSB = 0;
   localparam int FORMAT_LSB = 2;
   localparam int THREE_STATE_BIT = 6;
   localparam int BLANK_PASS_BIT = 7;
   localparam int RANGE_BIT = 0;
   localparam int EXTRA_LSB = 4;
   localparam int STREAM_REV_BIT = 7;
   localparam int LOW_PAIR_BIT = 4;
   localparam int HIGH_PAIR_BIT = 5;
   localparam int CHROMA_BLANK_BIT = 6;
   localparam int LOCK_IND_BIT = 7;
   localparam int MARGIN_LSB = 0;
   localparam int FIFO_RESET_BIT = 5;
   localparam int AUTO_RESET_BIT = 6;
   localparam int FLAG_TIMING_BIT = 7;
   localparam logic [1:0] MODE_LINE_LOCKED = 2'h0;
   localparam logic [1:0] MODE_INVALID = 2'h3;
   localparam logic [3:0] FMT_16BIT_422 = 4'h2;
   localparam logic [3:0] FMT_8BIT_422 = 4'h3;
   localparam logic [3:0] FMT_12BIT_411 = 4'h4;
   localparam logic [7:0] LUMA_MIN = 8'h10;
   localparam logic [7:0] LUMA_MAX = 8'hEB;
   localparam logic [7:0] CHROMA_MAX = 8'hF0;
   localparam logic [7:0] CHROMA_ZERO = 8'h80;
   localparam logic [9:0] BLANK_LAST_LINE = 10'h015;
   localparam logic [6:0] FIFO_DEPTH = 7'h40;
   localparam logic [6:0] FIFO_HALF = 7'h20;
   localparam int IRQ_FIFO_RESET = 0;
   localparam int IRQ_FIELD_END = 1;
   localparam int IRQ_BAD_CONFIG = 2;
   localparam int IRQ_LOCK_CHANGE = 3;
   typedef enum logic [3:0] {
      BUS_IDLE = 4'b0001,
      BUS_WRITE = 4'b0010,
      BUS_READ_WAIT = 4'b0100,
      BUS_READ_DONE = 4'b1000
   } bus_state_t;
endpackage

// ==== verif/pixel_sink_model.sv ====
// downstream pixel sink model that latches the bus each cycle pixel_oe is set and strobes once per beat clock change while pixel_oe is set
`timescale 1ns/1ns
`default_nettype none
module pixel_sink_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic accept,
   input wire logic [15:0] pixel_out,
   input wire logic pixel_oe,
   input wire logic half_rate_pixel_clock,
   output logic output_enable_n,
   output logic [15:0] word_seen,
   output logic word_stb
);
   logic beat_last_reg;
   assign output_enable_n = ~accept;
   // only a beat clock change counts, so a stale word is never taken twice
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         beat_last_reg <= 1'b0;
         word_stb <= 1'b0;
         word_seen <= 16'h0000;
      end
      else
      begin
         beat_last_reg <= half_rate_pixel_clock;
         word_stb <= pixel_oe & (half_rate_pixel_clock ^ beat_last_reg);
         word_seen <= pixel_oe ? pixel_out : ~word_seen;
      end
   end
endmodule
`default_nettype wire

// ==== verif/video_output_control_tb.sv ====
// self-checking bench for the video output control block
`timescale 1ns/1ns
`default_nettype none
module video_output_control_tb;
   import video_out_pkg::*;
   `define CHECK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, accept, word_stb;
   logic [31:0] haddr, hwdata, hrdata, seed, rd_val, ex;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] luma_in, chroma_in;
   logic [9:0] line_number;
   logic [6:0] fifo_level;
   logic pixel_valid, vertical_blank, field_end, horizontal_lock, tick_27mhz, external_input_clock, output_enable_n;
   logic [15:0] pixel_out, word_seen, pe, pk;
   logic [11:0] extra_data_out;
   logic [3:0] general_outputs, general_outputs_oe, oe_exp;
   logic pixel_oe, half_rate_pixel_clock, extra_data_oe, minimal_filter, full_range, stream_rev_new, fifo_reset;
   logic almost_empty_flag, almost_full_flag, half_full_flag, irq;
   int fails, checked, resets;
   logic [31:0] rq[$];
   logic [15:0] pq[$], pm[$];
   logic [3:0] fmts[5] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
   event rd_ev;
   assign hready = hreadyout;
   video_output_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
      .hresp, .hrdata, .luma_in, .chroma_in, .pixel_valid, .line_number, .vertical_blank, .field_end, .horizontal_lock,
      .fifo_level, .tick_27mhz, .external_input_clock, .output_enable_n, .pixel_out, .pixel_oe, .half_rate_pixel_clock,
      .extra_data_out, .extra_data_oe, .general_outputs, .general_outputs_oe, .minimal_filter, .full_range,
      .stream_rev_new, .fifo_reset, .almost_empty_flag, .almost_full_flag, .half_full_flag, .irq);
   pixel_sink_model sink (.hclk, .hresetn, .accept, .pixel_out, .pixel_oe, .half_rate_pixel_clock, .output_enable_n,
      .word_seen, .word_stb);
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // link clock free-runs, phase unrelated to hclk
   initial
   begin
      external_input_clock = 1'b0;
      #7;
      forever #200 external_input_clock = ~external_input_clock;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [15:0] pix(input logic [3:0] f, input logic rg, input logic bl, input logic [7:0] y,
      input logic [7:0] c, input logic ph);
      logic [7:0] yy, cc;
      yy = (!rg && y < LUMA_MIN) ? LUMA_MIN : (!rg && y > LUMA_MAX) ? LUMA_MAX : y;
      cc = (!rg && c < LUMA_MIN) ? LUMA_MIN : (!rg && c > CHROMA_MAX) ? CHROMA_MAX : c;
      cc = bl ? CHROMA_ZERO : cc;
      return (f == FMT_16BIT_422) ? {yy, cc} : (f == FMT_12BIT_411) ? {4'h0, yy, cc[7:4]} : {8'h00, ph ? yy : cc};
   endfunction
   task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h000000, idx, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, idx, d, r);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      rq.push_back(e);
      ahb(1'b0, idx, 32'h0, r);
      rd_val = r & m;
      ->rd_ev;
   endtask
   task automatic st(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic pulse(input logic t);
      @(posedge hclk);
      tick_27mhz <= t;
      field_end <= ~t;
      @(posedge hclk);
      tick_27mhz <= 1'b0;
      field_end <= 1'b0;
   endtask
   // even beat counts keep the 8-bit phase aligned between scenarios
   task automatic pixels(input logic [3:0] f, input logic rg, input logic bl);
      logic [7:0] y, c;
      wr(IDX_OUTPUT_CONTROL, {26'h0, f, 2'h0});
      wr(IDX_EXTENDED_OUTPUT_CONTROL, 32'h0C | {31'h0, rg});
      wr(IDX_GENERAL_PURPOSE_OUTPUT, {25'h0, bl, 6'h0});
      vertical_blank <= bl;
      st(4);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         y = (i == 0) ? 8'hFF : seed[7:0];
         c = (i == 0) ? 8'h01 : seed[15:8];
         pq.push_back(pix(f, rg, bl, y, c, i[0]));
         pm.push_back((f == FMT_8BIT_422) ? 16'h00FF : 16'hFFFF);
         @(posedge hclk);
         pixel_valid <= 1'b1;
         luma_in <= y;
         chroma_in <= c;
         @(posedge hclk);
         pixel_valid <= 1'b0;
      end
      st(4);
      vertical_blank <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(rd_ev)
   begin
      ex = rq.pop_front();
      `CHECK("hrdata", ex, rd_val)
      `CHECK("hresp", 1'b0, hresp)
   end
   always @(posedge hclk)
   begin
      if (word_stb === 1'b1)
      begin
         pe = pq.pop_front();
         pk = pm.pop_front();
         `CHECK("pixel_out", pe, word_seen & pk)
      end
      if (fifo_reset === 1'b1)
         resets++;
   end
   initial
   begin
      #1000000;
      fails++;
      wrap_up();
   end
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, luma_in, chroma_in, pixel_valid, line_number} = '0;
      {vertical_blank, field_end, horizontal_lock, fifo_level, tick_27mhz} = '0;
      hsize = 3'h2;
      accept = 1'b1;
      seed = 32'h00010666;
      st(4);
      hresetn <= 1'b1;
      rd(IDX_OUTPUT_CONTROL, 32'hFF, {24'h0, RST_OUTPUT_CONTROL});
      rd(IDX_EXTENDED_OUTPUT_CONTROL, 32'hFF, {24'h0, RST_EXTENDED_OUTPUT_CONTROL});
      rd(IDX_GENERAL_PURPOSE_OUTPUT, 32'hFF, {24'h0, RST_GENERAL_PURPOSE_OUTPUT});
      rd(IDX_FIFO_CONTROL, 32'hFF, 32'h04);
      rd(8'h20, 32'hFFFFFFFF, 32'h0);
      pixels(FMT_8BIT_422, 1'b0, 1'b0);
      pixels(FMT_16BIT_422, 1'b0, 1'b1);
      pixels(FMT_12BIT_411, 1'b1, 1'b0);
      pixels(FMT_16BIT_422, 1'b1, 1'b0);
      wr(IDX_EXTENDED_OUTPUT_CONTROL, 32'h9D);
      rd(IDX_EXTENDED_OUTPUT_CONTROL, 32'hFF, 32'h9D);
      `CHECK("extra_data_out", {pe[7:0], pe[11:8]}, extra_data_out)
      `CHECK("range_rev", 3'h7, {full_range, stream_rev_new, extra_data_oe})
      wr(IDX_EXTENDED_OUTPUT_CONTROL, 32'h0C);
      st(4);
      `CHECK("range_rev", 3'h0, {full_range, stream_rev_new, extra_data_oe})
      for (int m = 0; m < 4; m++)
      begin
         wr(IDX_OUTPUT_CONTROL, 32'h0C | m);
         st(4);
         `CHECK("pixel_oe", m != 3, pixel_oe)
      end
      for (int f = 0; f < 5; f++)
      begin
         wr(IDX_OUTPUT_CONTROL, {26'h0, fmts[f], 2'h0});
         st(4);
         `CHECK("pixel_oe", f < 3, pixel_oe)
      end
      wr(IDX_OUTPUT_CONTROL, 32'h4C);
      st(4);
      `CHECK("pixel_oe", 1'b0, pixel_oe)
      wr(IDX_OUTPUT_CONTROL, 32'h0C);
      accept <= 1'b0;
      st(6);
      `CHECK("pixel_oe", 1'b0, pixel_oe)
      accept <= 1'b1;
      wr(IDX_OUTPUT_CONTROL, 32'h8C);
      vertical_blank <= 1'b1;
      for (int l = 20; l < 23; l++)
      begin
         line_number <= 10'(l);
         st(4);
         `CHECK("minimal_filter", l <= 21, minimal_filter)
      end
      line_number <= 10'h005;
      wr(IDX_OUTPUT_CONTROL, 32'h0C);
      st(4);
      `CHECK("minimal_filter", 1'b0, minimal_filter)
      vertical_blank <= 1'b0;
      for (int e = 0; e < 4; e++)
      begin
         wr(IDX_GENERAL_PURPOSE_OUTPUT, {26'h0, e[1:0], 4'hA});
         st(4);
         oe_exp = {e[1], e[1], e[0], e[0]};
         `CHECK("gpo_oe", oe_exp, general_outputs_oe)
         `CHECK("gpo", 4'hA & oe_exp, general_outputs & oe_exp)
      end
      wr(IDX_OUTPUT_CONTROL, 32'h08);
      st(4);
      `CHECK("gpo_oe", 4'h0, general_outputs_oe)
      wr(IDX_OUTPUT_CONTROL, 32'h0D);
      wr(IDX_GENERAL_PURPOSE_OUTPUT, 32'h90);
      for (int h = 1; h >= 0; h--)
      begin
         horizontal_lock <= h[0];
         st(4);
         `CHECK("lock_pin", {1'b1, h[0]}, {general_outputs_oe[0], general_outputs[0]})
      end
      wr(IDX_FIFO_CONTROL, 32'h24);
      st(4);
      `CHECK("fifo_resets", 1, resets)
      rd(IDX_FIFO_CONTROL, 32'hFF, 32'h04);
      wr(IDX_FIFO_CONTROL, 32'h44);
      pulse(1'b0);
      wr(IDX_FIFO_CONTROL, 32'h04);
      pulse(1'b0);
      st(4);
      `CHECK("fifo_resets", 2, resets)
      // interrupt: raised, cleared, masked
      wr(IDX_IRQ_STATUS, 32'hF);
      wr(IDX_IRQ_MASK, 32'h2);
      pulse(1'b0);
      st(2);
      `CHECK("irq", 1'b1, irq)
      rd(IDX_IRQ_STATUS, 32'h2, 32'h2);
      wr(IDX_IRQ_STATUS, 32'h2);
      st(2);
      `CHECK("irq", 1'b0, irq)
      wr(IDX_IRQ_MASK, 32'h0);
      pulse(1'b0);
      st(2);
      `CHECK("irq", 1'b0, irq)
      wr(IDX_FIFO_CONTROL, 32'h80);
      fifo_level <= 7'h00;
      pulse(1'b1);
      st(4);
      `CHECK("flags", 3'h4, {almost_empty_flag, almost_full_flag, half_full_flag})
      fifo_level <= 7'h40;
      st(30);
      `CHECK("flags", 3'h4, {almost_empty_flag, almost_full_flag, half_full_flag})
      pulse(1'b1);
      st(4);
      `CHECK("flags", 3'h3, {almost_empty_flag, almost_full_flag, half_full_flag})
      wr(IDX_FIFO_CONTROL, 32'h04);
      fifo_level <= 7'h04;
      st(30);
      `CHECK("flags", 3'h4, {almost_empty_flag, almost_full_flag, half_full_flag})
      rd(IDX_BLOCK_STATE, 32'hFF, 32'h12);
      wrap_up();
   end
endmodule
`default_nettype wire
